// ===== fpld_pkg.sv
/*
  Constants, types and register map for the extension-register load and
  fused-negate decode block.
  Assumes an APB master, a data memory port and a fused multiply-add unit outside.
*/
package fpld_pkg;
  localparam logic [7:0] FPLD_CTRL_ADDR = 8'h00;
  localparam logic [7:0] FPLD_INSTR_ADDR = 8'h04;
  localparam logic [7:0] FPLD_BASE_ADDR = 8'h08;
  localparam logic [7:0] FPLD_PC_ADDR = 8'h0c;
  localparam logic [7:0] FPLD_STATUS_ADDR = 8'h10;
  localparam logic [7:0] FPLD_WBVAL_ADDR = 8'h14;
  localparam int FPLD_CTRL_COND = 0;
  localparam int FPLD_CTRL_FPEN = 1;
  localparam int FPLD_CTRL_BIGEND = 2;
  localparam int FPLD_ST_BUSY = 0;
  localparam int FPLD_ST_OUT_LSB = 1;
  localparam int FPLD_ST_FLAG_LSB = 5;
  localparam int FPLD_ST_ABORT = 10;
  localparam logic [2:0] FPLD_CTRL_RESET = 3'h0;
  localparam logic [3:0] FPLD_SP_CODE = 4'hd;
  localparam logic [3:0] FPLD_PC_CODE = 4'hf;
  localparam logic [31:0] FPLD_WORD_STEP = 32'h0000_0004;
  localparam logic [8:0] FPLD_REG_LIMIT = 9'h020;
  localparam logic [7:0] FPLD_DBL_MAX = 8'h10;

  typedef enum logic [3:0] {
    OUT_NONE = 4'h0,
    OUT_DONE = 4'h1,
    OUT_CONDFAIL = 4'h2,
    OUT_UNDEF = 4'h3,
    OUT_XFER64 = 4'h4,
    OUT_POP = 4'h5,
    OUT_UNPRED = 4'h6,
    OUT_NOMATCH = 4'h7,
    OUT_ABORT = 4'h8
  } fpld_outcome_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MEM = 2'b01,
    ST_FMA = 2'b10
  } fpld_state_t;

  typedef struct packed {
    logic negOp1;
    logic negAddend;
    logic [4:0] dReg;
    logic [4:0] nReg;
    logic [4:0] mReg;
  } fpld_fma_t;

  typedef struct packed {
    logic dbl;
    logic [4:0] num;
    logic [63:0] data;
  } fpld_regwr_t;
endpackage

// ===== fpld_decode.sv
/*
  Decode and execution of the fused negate multiply forms and the
  extension-register multi and single loads, controlled over APB.
  Assumes the fused multiply-add unit answers fmaDone once per fmaStart,
  and data memory answers each read with memAck, flagging memErr on a fault.
*/
// The implementer's own choices: the placing of the registers and the APB slave port.
module fpld_decode
  import fpld_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // data memory read port
  output logic memRead,
  output logic [31:0] memAddr,
  input wire logic memAck,
  input wire logic memErr,
  input wire logic [31:0] memRdata,
  // extension register write port
  output logic regWr,
  output fpld_regwr_t regWrData,
  // core register write-back
  output logic coreWr,
  output logic [3:0] coreNum,
  output logic [31:0] coreData,
  // fused multiply-add unit
  output logic fmaStart,
  output fpld_fma_t fmaOp,
  input wire logic fmaDone,
  input wire logic [4:0] fmaFlags
);
  logic [2:0] ctrl;
  logic [31:0] instr, baseVal, pcVal, wbVal, word1;
  logic [4:0] fpFlags;
  logic abortFlag, halfSel, dblMode, bigEnd;
  logic [5:0] wordsLeft;
  logic [4:0] curReg;
  fpld_outcome_t outcome;
  fpld_state_t state;

  // apb decode; the answer comes one cycle after the access phase opens
  wire apbAcc = psel && penable && !pready;
  wire apbWr = psel && penable && pready && pwrite;
  wire selCtrl = paddr == FPLD_CTRL_ADDR;
  wire selInstr = paddr == FPLD_INSTR_ADDR;
  wire selBase = paddr == FPLD_BASE_ADDR;
  wire selPc = paddr == FPLD_PC_ADDR;
  wire selStat = paddr == FPLD_STATUS_ADDR;
  wire selWb = paddr == FPLD_WBVAL_ADDR;
  wire mapped = selCtrl | selInstr | selBase | selPc | selStat | selWb;
  wire [31:0] statWord = {21'h0, abortFlag, fpFlags, outcome, state != ST_IDLE};
  wire [31:0] rdMux = selCtrl ? {29'h0, ctrl} : selInstr ? instr : selBase ? baseVal :
                      selPc ? pcVal : selStat ? statWord : selWb ? wbVal : 32'h0;
  // a new instruction is only taken while idle; otherwise the write is dropped
  wire start = apbWr && selInstr && state == ST_IDLE;

  // instruction fields, decoded straight from the write data
  wire [31:0] iw = pwdata;
  wire bitP = iw[24];
  wire bitU = iw[23];
  wire bitD = iw[22];
  wire bitW = iw[21];
  wire [3:0] baseCoreRegField = iw[19:16];
  wire [3:0] targetRegField = iw[15:12];
  wire dblForm = iw[8];
  wire [7:0] offsetWordCount = iw[7:0];
  wire isLoad = iw[31:25] == 7'h76 && iw[20] && iw[11:9] == 3'h5;
  wire isFnm = iw[31:23] == 9'h1dd && iw[21:20] == 2'h1 && iw[11:8] == 4'ha && !iw[4];
  wire condPass = ctrl[FPLD_CTRL_COND];
  wire fpEnable = ctrl[FPLD_CTRL_FPEN];

  wire seeXfer = !bitP && !bitU && !bitW;
  wire seePop = !bitP && bitU && bitW && baseCoreRegField == FPLD_SP_CODE;
  wire singleLoad = bitP && !bitW;
  wire encUndef = bitP == bitU && bitW;
  // what is left is PUW 010, 011 or 101
  wire multiLoad = !seeXfer && !seePop && !singleLoad && !encUndef;

  wire [4:0] dblFirst = {bitD, targetRegField};
  wire [4:0] sglFirst = {targetRegField, bitD};
  wire [4:0] firstReg = dblForm ? dblFirst : sglFirst;
  wire [7:0] regCount = dblForm ? {1'b0, offsetWordCount[7:1]} : offsetWordCount;
  wire [8:0] regEnd = {4'h0, firstReg} + {1'b0, regCount};
  wire [31:0] byteOffset = {22'h0, offsetWordCount, 2'b00};
  wire multiBad = baseCoreRegField == FPLD_PC_CODE || regCount == 8'h00 || regEnd > FPLD_REG_LIMIT ||
                  (dblForm && regCount > FPLD_DBL_MAX);
  wire [31:0] multiWords = dblForm ? {23'h0, regCount, 1'b0} : {24'h0, regCount};

  // literal loads take the word-aligned pc as base
  wire [31:0] loadBase = (singleLoad && baseCoreRegField == FPLD_PC_CODE) ? {pcVal[31:2], 2'b00} : baseVal;
  wire [31:0] basePlus = loadBase + byteOffset;
  wire [31:0] baseMinus = loadBase - byteOffset;
  // a subtracted zero offset yields the same address as an added one
  wire [31:0] singleAddr = bitU ? basePlus : baseMinus;
  wire [31:0] multiAddr = bitU ? loadBase : baseMinus;
  wire [31:0] multiWbVal = bitU ? basePlus : baseMinus;

  // checks are ordered so that nothing moves unless all of them pass
  fpld_outcome_t decOutcome;
  assign decOutcome = !(isLoad || isFnm) ? OUT_NOMATCH :
                      !condPass ? OUT_CONDFAIL :
                      isFnm ? (fpEnable ? OUT_NONE : OUT_UNDEF) :
                      seeXfer ? OUT_XFER64 :
                      seePop ? OUT_POP :
                      encUndef ? OUT_UNDEF :
                      !fpEnable ? OUT_UNDEF :
                      (multiLoad && multiBad) ? OUT_UNPRED : OUT_NONE;
  wire goFma = start && isFnm && decOutcome == OUT_NONE;
  wire goLoad = start && isLoad && decOutcome == OUT_NONE;
  wire goWb = goLoad && multiLoad && bitW;

  // memory side
  wire memBeat = state == ST_MEM && memRead && memAck;
  wire beatOk = memBeat && !memErr;
  wire lastBeat = wordsLeft == 6'h01;
  wire regBeat = beatOk && (!dblMode || halfSel);
  wire [63:0] dblData = bigEnd ? {word1, memRdata} : {memRdata, word1};
  wire [63:0] beatData = dblMode ? dblData : {32'h0, memRdata};

  // apb answer, one wait state
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= apbAcc;
      pslverr <= apbAcc && !mapped;
      prdata <= (apbAcc && !pwrite) ? rdMux : 32'h0;
    end
  end

  // software-written registers
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ctrl <= FPLD_CTRL_RESET;
      instr <= 32'h0;
      baseVal <= 32'h0;
      pcVal <= 32'h0;
    end else if (apbWr) begin
      if (selCtrl) ctrl <= pwdata[2:0];
      if (start) instr <= pwdata;
      if (selBase) baseVal <= pwdata;
      if (selPc) pcVal <= pwdata;
    end
  end

  // sticky flags: a hardware set in the clearing cycle wins
  wire [4:0] flagSet = (state == ST_FMA && fmaDone) ? fmaFlags : 5'h00;
  wire [4:0] flagClr = (apbWr && selStat) ? pwdata[9:5] : 5'h00;
  wire abortSet = memBeat && memErr;
  wire abortClr = apbWr && selStat && pwdata[FPLD_ST_ABORT];
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      fpFlags <= 5'h00;
      abortFlag <= 1'b0;
    end else begin
      fpFlags <= (fpFlags & ~flagClr) | flagSet;
      abortFlag <= (abortFlag && !abortClr) || abortSet;
    end
  end

  // sequencer
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      outcome <= OUT_NONE;
      memRead <= 1'b0;
      memAddr <= 32'h0;
      wordsLeft <= 6'h00;
      curReg <= 5'h00;
      dblMode <= 1'b0;
      bigEnd <= 1'b0;
      halfSel <= 1'b0;
      word1 <= 32'h0;
      fmaStart <= 1'b0;
      fmaOp <= '0;
      coreWr <= 1'b0;
      coreNum <= 4'h0;
      coreData <= 32'h0;
      wbVal <= 32'h0;
    end else begin
      fmaStart <= goFma;
      coreWr <= goWb;
      unique case (state)
        ST_IDLE: begin
          if (start) outcome <= decOutcome;
          if (goFma) begin
            state <= ST_FMA;
            fmaOp <= '{negOp1: iw[6], negAddend: 1'b1, dReg: {targetRegField, bitD},
                       nReg: {iw[19:16], iw[7]}, mReg: {iw[3:0], iw[5]}};
          end
          if (goLoad) begin
            state <= ST_MEM;
            memRead <= 1'b1;
            memAddr <= multiLoad ? multiAddr : singleAddr;
            wordsLeft <= multiLoad ? multiWords[5:0] : (dblForm ? 6'h02 : 6'h01);
            curReg <= firstReg;
            dblMode <= dblForm;
            bigEnd <= ctrl[FPLD_CTRL_BIGEND];
            halfSel <= 1'b0;
          end
          if (goWb) begin
            coreNum <= baseCoreRegField;
            coreData <= multiWbVal;
            wbVal <= multiWbVal;
          end
        end
        ST_FMA: begin
          if (fmaDone) begin
            state <= ST_IDLE;
            outcome <= OUT_DONE;
          end
        end
        ST_MEM: begin
          if (memBeat && memErr) begin
            // a fault ends the transfer; registers already loaded stay loaded
            state <= ST_IDLE;
            memRead <= 1'b0;
            outcome <= OUT_ABORT;
          end else if (beatOk) begin
            memAddr <= memAddr + FPLD_WORD_STEP;
            wordsLeft <= wordsLeft - 6'h01;
            halfSel <= dblMode && !halfSel;
            if (dblMode && !halfSel) word1 <= memRdata;
            if (regBeat) curReg <= curReg + 5'h01;
            if (lastBeat) begin
              state <= ST_IDLE;
              memRead <= 1'b0;
              outcome <= OUT_DONE;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // extension register write, one per completed register
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      regWr <= 1'b0;
      regWrData <= '0;
    end else begin
      regWr <= regBeat;
      if (regBeat) regWrData <= '{dbl: dblMode, num: curReg, data: beatData};
    end
  end

  sequence s_load_start;
    start && isLoad && condPass;
  endsequence

  property p_cond_quiet;
    @(posedge ref_clk) disable iff (!rst_b)
      (start && (isLoad || isFnm) && !condPass) |=> (outcome == OUT_CONDFAIL && !memRead && !coreWr && !fmaStart);
  endproperty
  a_cond_quiet: assert property (p_cond_quiet) else $error("side effect despite failed condition");

  property p_xfer;
    @(posedge ref_clk) disable iff (!rst_b)
      (s_load_start and (!bitP && !bitU && !bitW)) |=> (outcome == OUT_XFER64 && state == ST_IDLE);
  endproperty
  a_xfer: assert property (p_xfer) else $error("PUW 000 not redirected");

  property p_pop;
    @(posedge ref_clk) disable iff (!rst_b)
      (s_load_start and (!bitP && bitU && bitW && baseCoreRegField == 4'hd)) |=> outcome == OUT_POP;
  endproperty
  a_pop: assert property (p_pop) else $error("stack pop form not redirected");

  property p_undef;
    @(posedge ref_clk) disable iff (!rst_b)
      (s_load_start and (bitP == bitU && bitW)) |=> (outcome == OUT_UNDEF && !memRead);
  endproperty
  a_undef: assert property (p_undef) else $error("P equal U with W not undefined");

  property p_abort;
    @(posedge ref_clk) disable iff (!rst_b)
      (memRead && memAck && memErr) |=> (!memRead && abortFlag && outcome == OUT_ABORT) [*2];
  endproperty
  a_abort: assert property (p_abort) else $error("memory fault not raised as abort");

  property p_step;
    @(posedge ref_clk) disable iff (!rst_b)
      (memRead && memAck && !memErr && wordsLeft > 6'h01) |=> (memRead && memAddr == $past(memAddr) + 32'h4);
  endproperty
  a_step: assert property (p_step) else $error("address did not advance by one word");

  property p_fma;
    @(posedge ref_clk) disable iff (!rst_b)
      fmaStart |-> (fmaOp.negAddend && fmaOp.negOp1 == instr[6] && state == ST_FMA);
  endproperty
  a_fma: assert property (p_fma) else $error("fused negate controls wrong");

  property p_flags;
    @(posedge ref_clk) disable iff (!rst_b)
      (state == ST_FMA && fmaDone) |=> ((fpFlags & $past(fmaFlags)) == $past(fmaFlags));
  endproperty
  a_flags: assert property (p_flags) else $error("fp exception flag lost");

  property p_wback;
    @(posedge ref_clk) disable iff (!rst_b)
      coreWr |-> (memRead && coreData == (instr[23] ? memAddr + {22'h0, instr[7:0], 2'b00} : memAddr));
  endproperty
  a_wback: assert property (p_wback) else $error("write-back value inconsistent with start address");
endmodule

// ===== fpld_partner.sv
/*
  Model of the data memory and the fused multiply-add unit beside the decode block.
  Assumes one clock and the synchronous active-low reset of the block.
*/
module fpld_partner
  import fpld_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // data memory
  input wire logic memRead,
  input wire logic [31:0] memAddr,
  output logic memAck,
  output logic memErr,
  output logic [31:0] memRdata,
  // fused unit
  input wire logic fmaStart,
  output logic fmaDone,
  output logic [4:0] fmaFlags,
  // scenario controls
  input wire logic [1:0] lat,
  input wire logic [31:0] errAddr,
  input wire logic [4:0] flags
);
  logic [1:0] cnt;
  logic [2:0] fmaCnt;
  // data outside an ack is the inverse pattern, so stale sampling shows up
  assign memErr = memAck && (memAddr == errAddr);
  assign memRdata = memAck ? {memAddr[15:0], ~memAddr[15:0]} : {~memAddr[15:0], memAddr[15:0]};
  assign fmaFlags = fmaDone ? flags : ~flags;
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      memAck <= 1'b0;
      cnt <= 2'h0;
      fmaDone <= 1'b0;
      fmaCnt <= 3'h0;
    end else begin
      memAck <= 1'b0;
      // one word per ack, after lat + 1 idle cycles
      if (memRead && !memAck) begin
        if (cnt >= lat) begin
          memAck <= 1'b1;
          cnt <= 2'h0;
        end else begin
          cnt <= cnt + 2'h1;
        end
      end
      fmaDone <= (fmaCnt == 3'h1);
      if (fmaStart) begin
        fmaCnt <= 3'h3;
      end else if (fmaCnt != 3'h0) begin
        fmaCnt <= fmaCnt - 3'h1;
      end
    end
  end
endmodule

// ===== test_fp_load_and_fused_negate_decode.sv
/*
  Self-checking bench for the decode block: APB stimulus, queues of observed outputs.
  Assumes the partner model answers memory reads and fused operations.
*/
module test_fp_load_and_fused_negate_decode
  import fpld_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, memAddr, memRdata, coreData, errAddr = 32'hffff_ffff, rd;
  logic pready, pslverr, memRead, memAck, memErr, regWr, coreWr, fmaStart, fmaDone, er;
  logic [3:0] coreNum;
  logic [4:0] fmaFlags, flags = 5'h0;
  logic [1:0] lat = 2'h1;
  fpld_regwr_t regWrData;
  fpld_fma_t fmaOp;
  fpld_regwr_t wrQ[$];
  fpld_fma_t fmaQ[$];
  logic [31:0] adrQ[$];
  logic [35:0] wbQ[$];
  int errors = 0, tests_run = 0;
  function automatic logic [31:0] ld(logic p, u, w, dbl, d, logic [3:0] vd, rn, logic [7:0] imm);
    return {7'h76, p, u, d, w, 1'b1, rn, vd, 3'b101, dbl, imm};
  endfunction
  function automatic logic [31:0] fnm(logic op, d, logic [3:0] vn, vd, logic n, m, logic [3:0] vm);
    return {8'hee, 1'b1, d, 2'b01, vn, vd, 4'ha, n, op, m, 1'b0, vm};
  endfunction
  function automatic logic [31:0] pat(logic [31:0] a);
    return {a[15:0], ~a[15:0]};
  endfunction
  localparam logic [31:0] INS [15] = '{ld(1,1,0,0,0,1,1,1), ld(1,1,0,0,0,1,1,1), fnm(0,0,1,1,0,0,1), 32'h0,
    ld(0,0,0,1,0,0,1,2), ld(0,1,1,1,0,0,13,2), ld(1,1,1,0,0,0,1,2), ld(0,0,1,0,0,0,1,2), ld(0,1,0,1,0,0,15,2),
    ld(0,1,0,1,0,0,1,0), ld(0,1,0,1,0,0,1,34), ld(0,1,0,1,1,15,1,4), ld(0,1,0,0,1,15,1,2),
    ld(0,1,0,1,0,0,1,32), ld(0,1,0,0,1,15,1,1)};
  localparam fpld_outcome_t OUTC [15] = '{OUT_CONDFAIL, OUT_UNDEF, OUT_UNDEF, OUT_NOMATCH, OUT_XFER64, OUT_POP,
    OUT_UNDEF, OUT_UNDEF, OUT_UNPRED, OUT_UNPRED, OUT_UNPRED, OUT_UNPRED, OUT_UNPRED, OUT_DONE, OUT_DONE};

  fpld_decode dut (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .memRead(memRead),
    .memAddr(memAddr), .memAck(memAck), .memErr(memErr), .memRdata(memRdata), .regWr(regWr),
    .regWrData(regWrData), .coreWr(coreWr), .coreNum(coreNum), .coreData(coreData), .fmaStart(fmaStart),
    .fmaOp(fmaOp), .fmaDone(fmaDone), .fmaFlags(fmaFlags));
  fpld_partner partner (.ref_clk(ref_clk), .rst_b(rst_b), .memRead(memRead), .memAddr(memAddr),
    .memAck(memAck), .memErr(memErr), .memRdata(memRdata), .fmaStart(fmaStart), .fmaDone(fmaDone),
    .fmaFlags(fmaFlags), .lat(lat), .errAddr(errAddr), .flags(flags));

  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (regWr === 1'b1) wrQ.push_back(regWrData);
    if (memRead === 1'b1 && memAck === 1'b1) adrQ.push_back(memAddr);
    if (coreWr === 1'b1) wbQ.push_back({coreNum, coreData});
    if (fmaStart === 1'b1) fmaQ.push_back(fmaOp);
  end

  task check(input logic [71:0] seen, input logic [71:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task finish_test();
    if (errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // status of the finished instruction is left in rd
  task run(input logic [31:0] ins);
    wrQ.delete();
    adrQ.delete();
    wbQ.delete();
    fmaQ.delete();
    apb(1'b1, FPLD_INSTR_ADDR, ins);
    repeat (80) begin
      apb(1'b0, FPLD_STATUS_ADDR, 32'h0);
      if (rd[FPLD_ST_BUSY] === 1'b0) break;
    end
  endtask

  task t_reset();
    apb(1'b0, FPLD_CTRL_ADDR, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, FPLD_STATUS_ADDR, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    check({er, rd}, {1'b1, 32'h0});
  endtask
  task t_table();
    for (int i = 0; i < 15; i++) begin
      apb(1'b1, FPLD_CTRL_ADDR, (i == 0) ? 32'h0 : (i < 3) ? 32'h1 : 32'h3);
      run(INS[i]);
      check(rd[4:1], OUTC[i]);
      check(wrQ.size() + wbQ.size() + fmaQ.size(), (i == 13) ? 16 : (i == 14) ? 1 : 0);
    end
  endtask
  task t_single();
    apb(1'b1, FPLD_BASE_ADDR, 32'h1000);
    run(ld(1,1,0,0,1,5,3,3));
    check(rd[4:1], OUT_DONE);
    check(adrQ[0], 32'h100c);
    check(wrQ[0], {1'b0, 5'd11, 32'h0, pat(32'h100c)});
    check(wbQ.size(), 0);
    run(ld(1,0,0,0,1,5,3,0));
    check(adrQ[0], 32'h1000);
  endtask
  task t_pcdbl();
    apb(1'b1, FPLD_CTRL_ADDR, 32'h7);
    apb(1'b1, FPLD_PC_ADDR, 32'h2003);
    lat <= 2'h2;
    run(ld(1,0,0,1,1,2,15,8'hff));
    check(adrQ[0], 32'h1c04);
    check(adrQ[1], 32'h1c08);
    check(wrQ[0], {1'b1, 5'd18, pat(32'h1c04), pat(32'h1c08)});
  endtask
  task t_multi();
    apb(1'b1, FPLD_CTRL_ADDR, 32'h3);
    apb(1'b1, FPLD_BASE_ADDR, 32'h100);
    lat <= 2'h0;
    run(ld(0,1,1,0,0,1,2,3));
    check(wbQ[0], {4'h2, 32'h10c});
    for (int i = 0; i < 3; i++) begin
      check(adrQ[i], 32'h100 + 4 * i);
      check(wrQ[i], {1'b0, 5'(2 + i), 32'h0, pat(32'h100 + 4 * i)});
    end
    apb(1'b0, FPLD_WBVAL_ADDR, 32'h0);
    check(rd, 32'h10c);
    run(ld(0,1,0,0,0,1,2,1));
    check({rd[4:1], 8'(wbQ.size())}, {OUT_DONE, 8'h0});
  endtask
  task t_multidb();
    apb(1'b1, FPLD_BASE_ADDR, 32'h400);
    run(ld(1,0,1,1,1,2,4,4));
    check(wbQ[0], {4'h4, 32'h3f0});
    for (int i = 0; i < 4; i++) check(adrQ[i], 32'h3f0 + 4 * i);
    check(wrQ[0], {1'b1, 5'd18, pat(32'h3f4), pat(32'h3f0)});
    check(wrQ[1], {1'b1, 5'd19, pat(32'h3fc), pat(32'h3f8)});
  endtask
  task t_abort();
    errAddr <= 32'h104;
    apb(1'b1, FPLD_BASE_ADDR, 32'h100);
    run(ld(0,1,0,0,0,1,2,3));
    check({rd[4:1], rd[FPLD_ST_ABORT], 8'(wrQ.size())}, {OUT_ABORT, 1'b1, 8'h1});
    errAddr <= 32'hffff_ffff;
    apb(1'b1, FPLD_STATUS_ADDR, 32'h400);
    apb(1'b0, FPLD_STATUS_ADDR, 32'h0);
    check(rd[FPLD_ST_ABORT], 1'b0);
  endtask
  task t_fnm();
    flags <= 5'h15;
    run(fnm(1,1,3,4,1,0,6));
    check({rd[4:1], rd[9:5]}, {OUT_DONE, 5'h15});
    check(fmaQ[0], {1'b1, 1'b1, 5'd9, 5'd7, 5'd12});
    flags <= 5'h0;
    run(fnm(0,0,1,2,0,1,3));
    check(fmaQ[0], {1'b0, 1'b1, 5'd4, 5'd2, 5'd7});
    check(rd[9:5], 5'h15);
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    finish_test();
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_reset();
    t_table();
    t_single();
    t_pcdbl();
    t_multi();
    t_multidb();
    t_abort();
    t_fnm();
    finish_test();
  end
endmodule
